// file: logic/gipc_pkg.sv
// Purpose: Constants and types for the instrument-side bus port configuration block
// Assumes: 100 MHz system clock, Avalon-MM word registers
// Notes:   Offsets are byte addresses; each register takes one aligned word
package gipc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TONLY_PERIOD_S  = 5;
  localparam int unsigned TONLY_CYC       = TONLY_PERIOD_S * CLK_HZ;
  localparam logic [1:0]  STRAP_SETTLE    = 2'h3;

  // ----------------------------------------------------------------
  // Strap positions (index 0 is switch 1), address range, defaults
  // ----------------------------------------------------------------
  localparam int          SW_ADDR_LSB     = 0;
  localparam int          SW_UNUSED       = 5;
  localparam int          SW_SRQ          = 6;
  localparam int          SW_TONLY        = 7;
  localparam logic [4:0]  ADDR_MAX        = 5'h1E;
  localparam logic [4:0]  ADDR_RESET      = 5'h08;

  // ----------------------------------------------------------------
  // Serial poll status byte bits
  // ----------------------------------------------------------------
  localparam int          STB_MAV         = 4;
  localparam int          STB_ERR         = 6;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0]  OFS_CFG         = 5'h00;
  localparam logic [4:0]  OFS_STATE       = 5'h04;
  localparam logic [4:0]  OFS_IRQ_STAT    = 5'h08;
  localparam logic [4:0]  OFS_IRQ_MASK    = 5'h0C;
  localparam logic [4:0]  OFS_CTRL        = 5'h10;
  localparam logic [2:0]  IRQ_MASK_RESET  = 3'h0;
  localparam logic        CTRL_RUN_RESET  = 1'b1;

  // Interrupt status bit positions
  localparam int          IRQ_SENT        = 0;
  localparam int          IRQ_POLL        = 1;
  localparam int          IRQ_ERR         = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GIPC_IDLE = 2'b00,
    GIPC_SRQ  = 2'b01,
    GIPC_SEND = 2'b11
  } gipc_state_type;

  typedef struct packed {
    logic [4:0] addr;
    logic       talk_only;
    logic       srq_mode;
    logic       addr_err;
    logic       latched;
  } gipc_cfg_type;

  typedef struct packed {
    logic        pressure;
    logic        err;
    logic [1:0]  nval;
    logic [31:0] v0;
    logic [31:0] v1;
    logic [31:0] v2;
  } gipc_msg_type;

endpackage

// file: logic/gipc_port.sv
// Purpose: Strap capture, talk-only pacing and service request handling of the instrument port
// Assumes: Talker/listener engine on the same clock gives one-cycle pulses
// Notes:   Straps are captured once after reset release; later changes are ignored
//
// Contract
// [R1] Straps are sampled once at power-up and never again until the next power cycle.
// [R2] The bus address lies between 0 and 30 and the bus owner keeps it unique.
// [R3] The address is the sum of weights 16, 8, 4, 2, 1 of the five address switches that read OFF.
// [R4] With the switches as delivered the port answers at address 8.
// [R5] Switch 8 OFF at power-up selects talk-only operation, ON disables it.
// [R6] In talk-only operation a message with all three display pressures goes out about every 5 seconds.
// [R7] Without the second gauge module the talk-only message carries only the ion gauge pressure.
// [R8] Switch 7 OFF at power-up makes the port assert SRQ and wait for a serial poll before each message.
// [R9] SRQ is released by a serial poll or by reading the pending message.
// [R10] The serial poll status byte has bit 4 set as message available.
// [R11] After an error bit 6 of the status byte is set and the pending message is an error message.
// [R12] Switch 6 is ignored.
// [R13] Outside talk-only operation data goes out only in reply to host commands.
// [R14] In SRQ operation the controller answers each request with a poll or a read.
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
module gipc_port
  import gipc_pkg::*;
#(
  parameter int unsigned TONLY_CYCLES = TONLY_CYC
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Strap pins, 1 = switch OFF
  input  wire logic [7:0]   sw_off,
  // Pressure sources
  input  wire logic [31:0]  press_ion,
  input  wire logic [31:0]  press_cg_a,
  input  wire logic [31:0]  press_cg_b,
  input  wire logic         cg_present,
  // Command engine
  input  wire logic         reply_rdy,
  input  wire logic [31:0]  reply_data,
  input  wire logic         err_evt,
  // Talker engine
  input  wire logic         spoll,
  input  wire logic         msg_read,
  output logic              msg_valid,
  output gipc_msg_type      msg,
  output logic              srq,
  output logic [7:0]        stb,
  output logic [4:0]        bus_addr,
  output logic              talk_only,
  // Avalon-MM slave
  input  wire logic [2:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  // Interrupt
  output logic              irq
);

  // ----------------------------------------------------------------
  // Strap synchroniser and one-time capture
  // ----------------------------------------------------------------
  logic [7:0]     sw_s1_q, sw_s2_q, sw_s3_q;
  logic [1:0]     settle_q;
  gipc_cfg_type   cfg_q;
  logic [4:0]     sw_addr;
  wire            sw_agree = (sw_s2_q == sw_s3_q);

  // Address straps weigh 16..1 when OFF; switch 6 never looked at
  assign sw_addr = sw_s3_q[SW_ADDR_LSB +: 5]; // [R3] [R12]

  // Three stages; only s2 and s3 are compared
  always_ff @(posedge clk_sys) begin
    sw_s1_q <= sw_off;
    sw_s2_q <= sw_s1_q;
    sw_s3_q <= sw_s2_q;
  end

  // Capture once when the pipe is full and stable; reset stands for power-up
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      settle_q <= 2'h0;
      cfg_q    <= '{addr: ADDR_RESET, default: 1'b0}; // [R4]
    end else begin
      if (settle_q != STRAP_SETTLE) begin
        settle_q <= settle_q + 2'h1;
      end
      if (!cfg_q.latched && settle_q == STRAP_SETTLE && sw_agree) begin // [R1]
        cfg_q.latched   <= 1'b1;
        cfg_q.addr      <= (sw_addr > ADDR_MAX) ? ADDR_MAX : sw_addr; // [R2]
        cfg_q.addr_err  <= (sw_addr > ADDR_MAX);
        cfg_q.talk_only <= sw_s3_q[SW_TONLY]; // [R5]
        cfg_q.srq_mode  <= sw_s3_q[SW_SRQ];   // [R8]
      end
    end
  end

  // ----------------------------------------------------------------
  // Talk-only pacing
  // ----------------------------------------------------------------
  logic [31:0]    tick_cnt_q;
  logic           tick_q;
  logic           run_q;
  wire            pacing = cfg_q.latched && cfg_q.talk_only && run_q;

  // Free-running period counter; software can stop it, which clears the count
  always_ff @(posedge clk_sys) begin
    if (rst || !pacing) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TONLY_CYCLES - 1); // [R6]
      tick_cnt_q <= (tick_cnt_q == TONLY_CYCLES - 1) ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Message sources and error latch
  // ----------------------------------------------------------------
  gipc_state_type state_q, state_d;
  logic           tick_pend_q, rep_pend_q, err_q;
  logic [31:0]    rep_data_q;
  wire            idle     = (state_q == GIPC_IDLE);
  wire            take_any = idle && (tick_pend_q || rep_pend_q || err_q);
  // A pending error is served first; tick and reply stay pending behind it
  wire            take_rep = take_any && !err_q && !tick_pend_q && rep_pend_q;
  wire            take_tck = take_any && !err_q && tick_pend_q;
  wire            sent     = (state_q == GIPC_SEND) && msg_read;
  wire            err_sent = sent && msg.err;

  // Pending flags: a new event wins over the clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_pend_q <= 1'b0;
      rep_pend_q  <= 1'b0;
      rep_data_q  <= 32'h0;
      err_q       <= 1'b0;
    end else begin
      tick_pend_q <= tick_q || (tick_pend_q && !take_tck);
      rep_pend_q  <= (reply_rdy && cfg_q.latched) || (rep_pend_q && !take_rep); // [R13]
      if (reply_rdy) begin
        rep_data_q <= reply_data;
      end
      err_q       <= err_evt || (err_q && !err_sent); // [R11]
    end
  end

  // ----------------------------------------------------------------
  // Message state machine
  // ----------------------------------------------------------------
  // Poll or read releases a waiting request
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      GIPC_IDLE: begin
        if (take_any) begin
          state_d = cfg_q.srq_mode ? GIPC_SRQ : GIPC_SEND; // [R8]
        end
      end
      GIPC_SRQ: begin
        if (msg_read) begin
          state_d = GIPC_IDLE; // [R9]
        end else if (spoll) begin
          state_d = GIPC_SEND; // [R9] [R14]
        end
      end
      GIPC_SEND: begin
        if (msg_read) begin
          state_d = GIPC_IDLE;
        end
      end
      default: begin
        state_d = GIPC_IDLE;
      end
    endcase
  end

  // Message body is built when the source is taken
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= GIPC_IDLE;
      msg     <= '0;
    end else begin
      state_q <= state_d;
      if (take_any) begin
        msg.err      <= err_q; // [R11]
        msg.pressure <= !err_q && take_tck;
        msg.v0       <= err_q ? 32'h0 : (take_tck ? press_ion : rep_data_q);
        msg.v1       <= (!err_q && take_tck && cg_present) ? press_cg_a : 32'h0; // [R7]
        msg.v2       <= (!err_q && take_tck && cg_present) ? press_cg_b : 32'h0;
        msg.nval     <= (!err_q && take_tck && cg_present) ? 2'h3 : 2'h1; // [R6] [R7]
      end
    end
  end

  // Port outputs, all registered
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      msg_valid <= 1'b0;
      srq       <= 1'b0;
      stb       <= 8'h00;
      bus_addr  <= ADDR_RESET;
      talk_only <= 1'b0;
    end else begin
      msg_valid <= (state_d == GIPC_SEND);
      srq       <= (state_d == GIPC_SRQ); // [R8] [R9]
      stb       <= 8'h00;
      stb[STB_MAV] <= (state_d != GIPC_IDLE); // [R10]
      stb[STB_ERR] <= (state_d != GIPC_IDLE) && (take_any ? err_q : msg.err); // [R11]
      bus_addr  <= cfg_q.addr;
      talk_only <= cfg_q.talk_only;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle per access
  // ----------------------------------------------------------------
  logic [2:0]  irq_stat_q, irq_mask_q;
  wire         req    = avs_read || avs_write;
  wire [4:0]   ofs    = {avs_address, 2'b00};
  wire         wr_ack = avs_write && !avs_waitrequest;
  wire [2:0]   w1c    = (wr_ack && ofs == OFS_IRQ_STAT) ? avs_writedata[2:0] : 3'h0;
  wire [2:0]   evt    = {err_evt, spoll, sent};
  logic [31:0] rd_mux;

  // Read decode; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0;
    unique case (ofs)
      OFS_CFG:      rd_mux = {21'h0, cfg_q, 2'h0}; // Address lands in bits 10..6
      OFS_STATE:    rd_mux = {20'h0, err_q, srq, state_q, stb};
      OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
      OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_q};
      OFS_CTRL:     rd_mux = {31'h0, run_q};
      default:      rd_mux = 32'h0;
    endcase
  end

  // Wait request drops for one cycle per request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Control, mask and sticky status; set beats write-one-to-clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= IRQ_MASK_RESET;
      run_q      <= CTRL_RUN_RESET;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= evt | (irq_stat_q & ~w1c);
      if (wr_ack && ofs == OFS_IRQ_MASK) begin
        irq_mask_q <= avs_writedata[2:0];
      end
      if (wr_ack && ofs == OFS_CTRL) begin
        run_q <= avs_writedata[0];
      end
      irq        <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule

// file: verification/gipc_port_assertions.sv
// Purpose: Port-level checks of the instrument port block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the port block
`timescale 1ns/1ns
module gipc_chk
  import gipc_pkg::*;
#(
  parameter int unsigned TONLY_CYCLES = TONLY_CYC
) (
  // Clock and reset
  input wire logic         clk_sys,
  input wire logic         rst,
  // Observed port signals
  input wire logic         cg_present,
  input wire logic         spoll,
  input wire logic         msg_read,
  input wire logic         msg_valid,
  input wire gipc_msg_type msg,
  input wire logic         srq,
  input wire logic [7:0]   stb,
  input wire logic [4:0]   bus_addr,
  input wire logic         talk_only
);
  // ----------------------------------------------------------------
  // Helper logic and assertions
  // ----------------------------------------------------------------
  logic [3:0] age_q;
  logic [3:0] age_d;

  // Cycles since release, saturating; straps are latched long before 8
  assign age_d = (age_q == 4'hF) ? age_q : age_q + 4'h1;
  always_ff @(posedge clk_sys) age_q <= rst ? 4'h0 : age_d;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  addr_range_a: assert property (bus_addr <= ADDR_MAX)
    else $error("bus address above 30");
  strap_hold_a: assert property (age_q >= 4'h8 |-> $stable(bus_addr) && $stable(talk_only))
    else $error("strap settings moved after capture");
  reset_addr_a: assert property (disable iff (1'b0) rst |=> bus_addr == ADDR_RESET)
    else $error("address not 8 after reset");
  mav_bit_a: assert property (msg_valid |-> stb[STB_MAV])
    else $error("message pending without bit 4");
  err_msg_a: assert property (msg_valid && stb[STB_ERR] |-> msg.err)
    else $error("error flagged but message is not an error");
  poll_send_a: assert property (srq && spoll && !msg_read |=> msg_valid && !srq)
    else $error("poll did not release the message");
  read_clear_a: assert property (msg_valid && msg_read |=> !msg_valid && !stb[STB_MAV])
    else $error("message stands after read");
  value_count_a: assert property (msg_valid && msg.pressure |-> msg.nval == (cg_present ? 2'h3 : 2'h1))
    else $error("wrong number of pressure values");
  srq_first_a: assert property (srq |-> !msg_valid)
    else $error("message out while service request pending");
endmodule

bind gipc_port gipc_chk #(.TONLY_CYCLES(TONLY_CYCLES)) u_chk (.clk_sys(clk_sys), .rst(rst), .cg_present(cg_present),
  .spoll(spoll), .msg_read(msg_read), .msg_valid(msg_valid), .msg(msg), .srq(srq), .stb(stb),
  .bus_addr(bus_addr), .talk_only(talk_only));

// file: verification/gipc_host.sv
// Purpose: Bus controller model facing the instrument port
// Assumes: Poll and read are one-cycle pulses
// Notes:   Random 1..4 cycle answer delay covers prompt and slow hosts
`timescale 1ns/1ns
module gipc_host (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Device side
  input  wire logic srq,
  input  wire logic msg_valid,
  output logic      spoll,
  output logic      msg_read
);
  // ----------------------------------------------------------------
  // Answer logic
  // ----------------------------------------------------------------
  int unsigned wait_q;

  initial begin
    spoll    = 1'b0;
    msg_read = 1'b0;
    wait_q   = 0;
  end

  // Re-arm after each pulse so one request never gets two answers
  always @(posedge clk_sys) begin
    spoll    <= 1'b0;
    msg_read <= 1'b0;
    if (rst || !(srq || msg_valid) || spoll || msg_read) begin
      wait_q <= 1 + $urandom_range(3);
    end else if (wait_q != 0) begin
      wait_q <= wait_q - 1;
    end else if (srq) begin
      spoll <= 1'b1;
    end else begin
      msg_read <= 1'b1;
    end
  end
endmodule

// file: verification/gipc_port_tb.sv
// Purpose: Self-checking bench of the instrument port block
// Assumes: Host model answers requests and reads messages
// Notes:   Talk-only pacing shortened to 200 cycles
`timescale 1ns/1ns
module gipc_port_tb
  import gipc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals, design and host
  // ----------------------------------------------------------------
  logic         clk_sys, rst, cg_present, reply_rdy, err_evt, spoll, msg_read, msg_valid, srq, talk_only, irq;
  logic         avs_read, avs_write, avs_waitrequest;
  logic [2:0]   avs_address;
  logic [4:0]   bus_addr;
  logic [7:0]   sw_off, stb, s;
  logic [31:0]  press_ion, press_cg_a, press_cg_b, reply_data, avs_writedata, avs_readdata, rd, d;
  gipc_msg_type msg;
  int           n_fail, comparisons;

  gipc_port #(.TONLY_CYCLES(200)) DUT (.clk_sys, .rst, .sw_off, .press_ion, .press_cg_a, .press_cg_b, .cg_present,
    .reply_rdy, .reply_data, .err_evt, .spoll, .msg_read, .msg_valid, .msg, .srq, .stb, .bus_addr, .talk_only,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
  gipc_host u_host (.clk_sys, .rst, .srq, .msg_valid, .spoll, .msg_read);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Address clamps at 30, switch 6 plays no part
  function automatic logic [4:0] exp_addr(input logic [7:0] v);
    return (v[4:0] > ADDR_MAX) ? ADDR_MAX : v[4:0];
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bail(input int n);
    if (n >= 1000) begin
      n_fail++;
      $display("unexpected at %0t: wait timed out", $time);
      give_verdict();
    end
  endtask

  // One Avalon word transfer, held until waitrequest samples low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= wd;
    // Settled level seen at the falling edge; taken at the next rising edge
    do begin
      @(negedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 1000);
    @(posedge clk_sys);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    bail(n);
  endtask

  // k: 0 message up, 1 service request up, 2 message gone
  task automatic wait_sig(input int k);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (n < 1000 && (k == 0 ? msg_valid : k == 1 ? srq : !msg_valid) !== 1'b1);
    bail(n);
  endtask

  task automatic restart(input logic [7:0] v);
    sw_off <= v;
    rst    <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic pulse(input logic e, input logic [31:0] v);
    @(posedge clk_sys);
    err_evt    <= e;
    reply_rdy  <= !e;
    reply_data <= v;
    @(posedge clk_sys);
    err_evt   <= 1'b0;
    reply_rdy <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {cg_present, reply_rdy, err_evt, avs_read, avs_write} = 5'h0;
    {press_ion, press_cg_a, press_cg_b, reply_data, avs_writedata} = 160'h0;
    avs_address = 3'h0;
    sw_off = 8'h08;
    n_fail = 0;
    comparisons = 0;
    void'($urandom(32'h7898));
    @(posedge clk_sys);
    restart(8'h08);
    chk(bus_addr, 32'h8);
    chk(talk_only, 32'h0);
    bus(1'b0, 3'h0, 32'h0);
    chk(rd[10:6], 32'h8);
    bus(1'b0, 3'h7, 32'h0);
    chk(rd, 32'h0);
    sw_off <= 8'h9F;
    repeat (300) @(negedge clk_sys);
    chk(bus_addr, 32'h8);
    chk(msg_valid, 32'h0);
    $display("test done: defaults");
    d = $urandom;
    pulse(1'b0, d);
    wait_sig(0);
    chk(msg.v0, d);
    chk(stb[STB_MAV], 32'h1);
    chk(srq, 32'h0);
    wait_sig(2);
    repeat (2) @(negedge clk_sys);
    chk(irq, 32'h0);
    bus(1'b1, 3'h3, 32'h7);
    repeat (2) @(negedge clk_sys);
    chk(irq, 32'h1);
    bus(1'b1, 3'h2, 32'h7);
    repeat (2) @(negedge clk_sys);
    chk(irq, 32'h0);
    pulse(1'b1, 32'h0);
    wait_sig(0);
    chk(msg.err, 32'h1);
    chk(stb[STB_ERR], 32'h1);
    wait_sig(2);
    $display("test done: reply, interrupt, error");
    for (int i = 0; i < 6; i++) begin
      s = $urandom;
      d = $urandom;
      if (i == 0) s[4:0] = 5'h1F;
      if (i < 4) s[7:6] = i[1:0];
      @(posedge clk_sys);
      cg_present <= d[0];
      press_ion  <= $urandom;
      press_cg_a <= $urandom;
      press_cg_b <= $urandom;
      restart(s);
      chk(bus_addr, exp_addr(s));
      chk(talk_only, s[SW_TONLY]);
      if (!s[SW_TONLY]) pulse(1'b0, d);
      if (s[SW_SRQ]) begin
        wait_sig(1);
        chk(msg_valid, 32'h0);
      end
      wait_sig(0);
      chk(msg.pressure, s[SW_TONLY]);
      chk(msg.v0, s[SW_TONLY] ? press_ion : d);
      if (s[SW_TONLY]) chk(msg.nval, cg_present ? 32'h3 : 32'h1);
      wait_sig(2);
      $display("test done: straps %h", s);
    end
    give_verdict();
  end
endmodule
